/* File: hdl/qei_pkg.sv */
package qei_pkg;
   localparam int          DATA_W        = 32;
   localparam int          ADDR_W        = 8;
   localparam int          POS_W         = 16;
   localparam int          FILT_W        = 8;
   localparam int          NUM_MOD       = 2;
   localparam int          NUM_IN        = 4;
   localparam int          NUM_LANE      = NUM_MOD * NUM_IN;
   localparam int          IRQ_W         = 6;
   // input kinds inside one module
   localparam int          IN_A          = 0;
   localparam int          IN_B          = 1;
   localparam int          IN_I          = 2;
   localparam int          IN_S          = 3;
   // path select field layout and clock disable bit
   localparam int          LANE_STRIDE   = 8;
   localparam int          SYNC_BIT_OFS  = 0;
   localparam int          FILT_BIT_OFS  = 1;
   localparam int          CLK_DIS_BIT   = 9;
   // interrupt status layout
   localparam int          IRQ_ERR_LSB   = 0;
   localparam int          IRQ_CMP_LSB   = 2;
   localparam int          IRQ_IDX_LSB   = 4;
   // register byte offsets
   localparam logic [7:0]  OFS_CLK_DIS   = 8'h00;
   localparam logic [7:0]  OFS_PATH_SEL  = 8'h04;
   localparam logic [7:0]  OFS_FILT_W    = 8'h08;
   localparam logic [7:0]  OFS_ERR_SEL   = 8'h0c;
   localparam logic [7:0]  OFS_IRQ_STAT  = 8'h10;
   localparam logic [7:0]  OFS_IRQ_CLR   = 8'h14;
   localparam logic [7:0]  OFS_IRQ_EN    = 8'h18;
   localparam logic [7:0]  OFS_POS0      = 8'h1c;
   localparam logic [7:0]  OFS_POS1      = 8'h20;
   localparam logic [7:0]  OFS_CMP0      = 8'h24;
   localparam logic [7:0]  OFS_CMP1      = 8'h28;
   localparam logic [7:0]  OFS_LATCH0    = 8'h2c;
   localparam logic [7:0]  OFS_LATCH1    = 8'h30;
   // reset values
   localparam logic [31:0] RST_CLK_DIS   = 32'h0000_0000;
   localparam logic [31:0] RST_PATH_SEL  = 32'h0101_0101;
   localparam logic [7:0]  RST_FILT_W    = 8'h00;
   localparam logic [POS_W-1:0] RST_POS  = 16'h0000;
   localparam logic [POS_W-1:0] RST_CMP  = 16'hffff;
   // timing: clock period in ns, the rest in peripheral clock cycles at 100 MHz
   localparam int          CLK_PERIOD_NS = 10;
   localparam int          MIN_PULSE_CYC = 2;
   localparam int          COUNT_DLY_CYC = 4;
   localparam int          CMP_DLY_CYC   = 6;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_t;
endpackage : qei_pkg

/* File: hdl/input_conditioner.sv */
`timescale 1ns/1ps
module input_conditioner (
   input  wire logic                      mclk_i,          // peripheral clock
   input  wire logic                      rst_i,           // sync reset, high
   input  wire logic                      en_i,            // encoder clock running and ce
   input  wire logic                      raw_i,           // pin level
   input  wire logic                      sel_sync_i,      // double-sync path select
   input  wire logic                      sel_filt_i,      // filtered path select
   input  wire logic [qei_pkg::FILT_W-1:0] filter_width_i, // qualification cycles
   output logic                           cond_o           // conditioned level
);
   import qei_pkg::*;

   logic              sync1_reg;
   logic              sync2_reg;
   logic              filt_reg;
   logic [FILT_W-1:0] stab_reg;
   logic              use_filt;

   // both bits clear falls back to the plain path
   assign use_filt = !sel_sync_i && sel_filt_i; // R6 R7 R8 R9 R16

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         sync1_reg <= 1'b0;
         sync2_reg <= 1'b0;
      end else if (en_i) begin
         sync1_reg <= raw_i; // R15
         sync2_reg <= sync1_reg; // R15
      end
   end

   // filter sits behind the synchroniser, never on sync1
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         filt_reg <= 1'b0;
         stab_reg <= '0;
      end else if (en_i) begin
         if (sync2_reg == filt_reg) begin
            stab_reg <= '0;
         end else if (stab_reg >= filter_width_i) begin
            filt_reg <= sync2_reg;
            stab_reg <= '0;
         end else begin
            stab_reg <= stab_reg + 1'b1;
         end
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         cond_o <= 1'b0;
      end else if (en_i) begin
         cond_o <= use_filt ? filt_reg : sync2_reg; // R6 R7 R8 R9
      end
   end

   property p_plain_latency;
      @(posedge mclk_i) disable iff (rst_i)
      (en_i && !use_filt)[*4] |-> cond_o == $past(raw_i, 3);
   endproperty
   a_plain_latency: assert property (p_plain_latency) else $error("plain path latency wrong"); // R15

   property p_filt_hold;
      @(posedge mclk_i) disable iff (rst_i)
      (en_i && use_filt && $changed(filt_reg)) |-> $past(stab_reg) >= $past(filter_width_i);
   endproperty
   a_filt_hold: assert property (p_filt_hold) else $error("filter passed an unqualified level"); // R6
endmodule : input_conditioner

/* File: hdl/quadrature_encoder_integration.sv */
// The Avalon-MM register port and the register addresses are this design's own decisions.
`timescale 1ns/1ps
// Overview of operation
// R1 - bit 9 disable stops encoder clock domain
// R2 - encoder clock runs after reset
// R3 - illegal phase transition raises phase error
// R4 - mux selects which module's error forwards
// R5 - selected error inverted toward timer coprocessor
// R6 - phase A path chosen by bits 0,1
// R7 - phase B path chosen by bits 8,9
// R8 - index path chosen by bits 16,17
// R9 - strobe path chosen by bits 24,25
// R10 - encoder holds phase periods two cycles minimum
// R11 - encoder holds index levels two cycles
// R12 - encoder holds strobe levels two cycles
// R13 - counter reflects edge within four cycles
// R14 - compare sync answers within six cycles
// R15 - two flip-flop synchroniser before filter
// R16 - both bits clear means plain synchronised path
module quadrature_encoder_integration (
   input  wire logic                        mclk_i,                  // peripheral clock, 100 MHz
   input  wire logic                        rst_i,                   // sync reset, high
   input  wire logic                        ce_i,                    // clock enable, freezes all
   input  wire logic [qei_pkg::ADDR_W-1:0]  avs_address_i,           // byte address
   input  wire logic                        avs_read_i,              // read request
   input  wire logic                        avs_write_i,             // write request
   input  wire logic [qei_pkg::DATA_W-1:0]  avs_writedata_i,         // write data
   input  wire logic [3:0]                  avs_byteenable_i,        // byte lanes
   output logic      [qei_pkg::DATA_W-1:0]  avs_readdata_o,          // read data
   output logic                             avs_waitrequest_o,       // stall
   input  wire logic [qei_pkg::NUM_MOD-1:0] phase_a_in_i,            // phase A pins
   input  wire logic [qei_pkg::NUM_MOD-1:0] phase_b_in_i,            // phase B pins
   input  wire logic [qei_pkg::NUM_MOD-1:0] index_in_i,              // index pins
   input  wire logic [qei_pkg::NUM_MOD-1:0] strobe_in_i,             // strobe pins
   output logic      [qei_pkg::NUM_MOD-1:0] phase_error_out_o,       // per-module phase error
   output logic                             timer_phase_error_n_o,   // to timer coprocessor, inverted
   output logic      [qei_pkg::NUM_MOD-1:0] compare_sync_o,          // position compare sync
   output logic                             irq_o                    // level interrupt
);
   import qei_pkg::*;

   logic [DATA_W-1:0]   clk_dis_reg;
   logic [DATA_W-1:0]   path_sel_reg;
   logic [FILT_W-1:0]   filt_w_reg;
   logic                err_sel_reg;
   logic [IRQ_W-1:0]    irq_stat_reg;
   logic [IRQ_W-1:0]    irq_en_reg;
   logic [POS_W-1:0]    count_reg [NUM_MOD];
   logic [POS_W-1:0]    cmp_reg   [NUM_MOD];
   logic [POS_W-1:0]    latch_reg [NUM_MOD];
   logic [NUM_MOD-1:0]  prev_a_reg;
   logic [NUM_MOD-1:0]  prev_b_reg;
   logic [NUM_MOD-1:0]  prev_i_reg;
   logic [NUM_MOD-1:0]  prev_s_reg;
   logic [NUM_MOD-1:0]  step;
   logic [NUM_MOD-1:0]  up;
   logic [NUM_MOD-1:0]  bad;
   logic [NUM_MOD-1:0]  idx_rise;
   logic [NUM_MOD-1:0]  strb_rise;
   logic [NUM_MOD-1:0]  cmp_hit;
   logic [NUM_LANE-1:0] raw_vec;
   logic [NUM_LANE-1:0] cond_vec;
   logic                enc_en;
   logic                lane_en;
   bus_state_t          bus_state;
   logic [DATA_W-1:0]   rd_next;
   logic                wr_go;
   logic [DATA_W-1:0]   wmask;
   logic [IRQ_W-1:0]    irq_set;
   logic [IRQ_W-1:0]    irq_clr;

   // gating is a freeze of the encoder state, not a gated clock, to stay glitch free
   assign enc_en  = !clk_dis_reg[CLK_DIS_BIT]; // R1
   assign lane_en = enc_en && ce_i; // R1

   genvar g;
   generate
      for (g = 0; g < NUM_LANE; g++) begin : g_lane
         localparam int K = g % NUM_IN;
         input_conditioner u_cond (
            .mclk_i         (mclk_i),
            .rst_i          (rst_i),
            .en_i           (lane_en),
            .raw_i          (raw_vec[g]),
            .sel_sync_i     (path_sel_reg[K*LANE_STRIDE+SYNC_BIT_OFS]),
            .sel_filt_i     (path_sel_reg[K*LANE_STRIDE+FILT_BIT_OFS]),
            .filter_width_i (filt_w_reg),
            .cond_o         (cond_vec[g])
         );
      end
   endgenerate

   // encoder modules
   generate
      for (g = 0; g < NUM_MOD; g++) begin : g_mod
         logic a;
         logic b;
         logic ix;
         logic sb;
         assign raw_vec[g*NUM_IN+IN_A] = phase_a_in_i[g];
         assign raw_vec[g*NUM_IN+IN_B] = phase_b_in_i[g];
         assign raw_vec[g*NUM_IN+IN_I] = index_in_i[g];
         assign raw_vec[g*NUM_IN+IN_S] = strobe_in_i[g];
         assign a  = cond_vec[g*NUM_IN+IN_A];
         assign b  = cond_vec[g*NUM_IN+IN_B];
         assign ix = cond_vec[g*NUM_IN+IN_I];
         assign sb = cond_vec[g*NUM_IN+IN_S];
         assign step[g]      = (a ^ prev_a_reg[g]) ^ (b ^ prev_b_reg[g]);
         assign bad[g]       = (a ^ prev_a_reg[g]) & (b ^ prev_b_reg[g]); // R3
         assign up[g]        = a ^ prev_b_reg[g];
         assign idx_rise[g]  = ix && !prev_i_reg[g];
         assign strb_rise[g] = sb && !prev_s_reg[g];
         assign cmp_hit[g]   = count_reg[g] == cmp_reg[g];

         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               prev_a_reg[g] <= 1'b0;
               prev_b_reg[g] <= 1'b0;
               prev_i_reg[g] <= 1'b0;
               prev_s_reg[g] <= 1'b0;
            end else if (lane_en) begin
               prev_a_reg[g] <= a;
               prev_b_reg[g] <= b;
               prev_i_reg[g] <= ix;
               prev_s_reg[g] <= sb;
            end
         end

         // index wins over a step in the same cycle
         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               count_reg[g] <= RST_POS;
            end else if (lane_en) begin
               if (idx_rise[g]) begin
                  count_reg[g] <= RST_POS;
               end else if (step[g]) begin
                  count_reg[g] <= up[g] ? count_reg[g] + 1'b1 : count_reg[g] - 1'b1; // R13
               end
            end
         end

         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               latch_reg[g] <= RST_POS;
            end else if (lane_en && strb_rise[g]) begin
               latch_reg[g] <= count_reg[g];
            end
         end

         always_ff @(posedge mclk_i) begin
            if (rst_i) begin
               phase_error_out_o[g] <= 1'b0;
               compare_sync_o[g]    <= 1'b0;
            end else if (lane_en) begin
               phase_error_out_o[g] <= bad[g]; // R3
               compare_sync_o[g]    <= cmp_hit[g]; // R14
            end
         end

         property p_step_count;
            @(posedge mclk_i) disable iff (rst_i)
            (lane_en && step[g] && !idx_rise[g]) |=> count_reg[g] != $past(count_reg[g]);
         endproperty
         a_step_count: assert property (p_step_count) else $error("step did not move counter"); // R13

         property p_frozen;
            @(posedge mclk_i) disable iff (rst_i)
            !lane_en |=> $stable(count_reg[g]) && $stable(phase_error_out_o[g]);
         endproperty
         a_frozen: assert property (p_frozen) else $error("encoder moved while its clock was off"); // R1

         property p_err;
            @(posedge mclk_i) disable iff (rst_i)
            (lane_en && bad[g]) |=> phase_error_out_o[g] ##1 (!$past(lane_en) || irq_stat_reg[IRQ_ERR_LSB+g]);
         endproperty
         a_err: assert property (p_err) else $error("phase error not flagged"); // R3

         property p_cmp;
            @(posedge mclk_i) disable iff (rst_i)
            (lane_en && cmp_hit[g]) |=> compare_sync_o[g];
         endproperty
         a_cmp: assert property (p_cmp) else $error("compare sync missed"); // R14

         property p_cmp_low;
            @(posedge mclk_i) disable iff (rst_i)
            (lane_en && !cmp_hit[g]) |=> !compare_sync_o[g];
         endproperty
         a_cmp_low: assert property (p_cmp_low) else $error("compare sync without a match"); // R14
      end
   endgenerate

   // forwarded error follows the selected module's error one cycle later, low-active toward the timer
   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         timer_phase_error_n_o <= 1'b1;
      end else if (ce_i) begin
         timer_phase_error_n_o <= !(err_sel_reg ? phase_error_out_o[1] : phase_error_out_o[0]); // R4 R5
      end
   end

   property p_err_route;
      @(posedge mclk_i) disable iff (rst_i)
      (ce_i && phase_error_out_o[err_sel_reg]) |=> !timer_phase_error_n_o;
   endproperty
   a_err_route: assert property (p_err_route) else $error("selected error not forwarded inverted"); // R4 R5

   property p_err_idle;
      @(posedge mclk_i) disable iff (rst_i)
      (ce_i && !phase_error_out_o[err_sel_reg]) |=> timer_phase_error_n_o;
   endproperty
   a_err_idle: assert property (p_err_idle) else $error("timer error without selected error"); // R4 R5

   // register bus
   always_comb begin
      wmask = {{8{avs_byteenable_i[3]}}, {8{avs_byteenable_i[2]}},
               {8{avs_byteenable_i[1]}}, {8{avs_byteenable_i[0]}}};
   end

   // first edge loads read data and drops waitrequest; second edge commits
   assign wr_go = avs_write_i && (bus_state == BUS_ACK);

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         bus_state         <= BUS_IDLE;
         avs_waitrequest_o <= 1'b1;
         avs_readdata_o    <= '0;
      end else if (ce_i) begin
         case (bus_state)
            BUS_IDLE: begin
               if (avs_read_i || avs_write_i) begin
                  bus_state         <= BUS_ACK;
                  avs_waitrequest_o <= 1'b0;
                  avs_readdata_o    <= rd_next;
               end
            end
            BUS_ACK: begin
               bus_state         <= BUS_IDLE;
               avs_waitrequest_o <= 1'b1;
            end
            default: begin
               bus_state         <= BUS_IDLE;
               avs_waitrequest_o <= 1'b1;
            end
         endcase
      end
   end

   always_comb begin
      rd_next = '0;
      if (avs_address_i == OFS_CLK_DIS) begin
         rd_next = clk_dis_reg;
      end else if (avs_address_i == OFS_PATH_SEL) begin
         rd_next = path_sel_reg;
      end else if (avs_address_i == OFS_FILT_W) begin
         rd_next[FILT_W-1:0] = filt_w_reg;
      end else if (avs_address_i == OFS_ERR_SEL) begin
         rd_next[0] = err_sel_reg;
      end else if (avs_address_i == OFS_IRQ_STAT) begin
         rd_next[IRQ_W-1:0] = irq_stat_reg;
      end else if (avs_address_i == OFS_IRQ_EN) begin
         rd_next[IRQ_W-1:0] = irq_en_reg;
      end else if (avs_address_i == OFS_POS0) begin
         rd_next[POS_W-1:0] = count_reg[0];
      end else if (avs_address_i == OFS_POS1) begin
         rd_next[POS_W-1:0] = count_reg[1];
      end else if (avs_address_i == OFS_CMP0) begin
         rd_next[POS_W-1:0] = cmp_reg[0];
      end else if (avs_address_i == OFS_CMP1) begin
         rd_next[POS_W-1:0] = cmp_reg[1];
      end else if (avs_address_i == OFS_LATCH0) begin
         rd_next[POS_W-1:0] = latch_reg[0];
      end else if (avs_address_i == OFS_LATCH1) begin
         rd_next[POS_W-1:0] = latch_reg[1];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         clk_dis_reg  <= RST_CLK_DIS; // R2
         path_sel_reg <= RST_PATH_SEL;
         filt_w_reg   <= RST_FILT_W;
         err_sel_reg  <= 1'b0;
         irq_en_reg   <= '0;
         cmp_reg[0]   <= RST_CMP;
         cmp_reg[1]   <= RST_CMP;
      end else if (ce_i && wr_go) begin
         if (avs_address_i == OFS_CLK_DIS) begin
            clk_dis_reg <= (clk_dis_reg & ~wmask) | (avs_writedata_i & wmask); // R1
         end else if (avs_address_i == OFS_PATH_SEL) begin
            path_sel_reg <= (path_sel_reg & ~wmask) | (avs_writedata_i & wmask);
         end else if (avs_address_i == OFS_FILT_W && avs_byteenable_i[0]) begin
            filt_w_reg <= avs_writedata_i[FILT_W-1:0];
         end else if (avs_address_i == OFS_ERR_SEL && avs_byteenable_i[0]) begin
            err_sel_reg <= avs_writedata_i[0];
         end else if (avs_address_i == OFS_IRQ_EN && avs_byteenable_i[0]) begin
            irq_en_reg <= avs_writedata_i[IRQ_W-1:0];
         end else if (avs_address_i == OFS_CMP0) begin
            cmp_reg[0] <= (cmp_reg[0] & ~wmask[POS_W-1:0]) | (avs_writedata_i[POS_W-1:0] & wmask[POS_W-1:0]);
         end else if (avs_address_i == OFS_CMP1) begin
            cmp_reg[1] <= (cmp_reg[1] & ~wmask[POS_W-1:0]) | (avs_writedata_i[POS_W-1:0] & wmask[POS_W-1:0]);
         end
      end
   end

   // interrupts, set wins over clear
   always_comb begin
      irq_set = {idx_rise & {NUM_MOD{lane_en}}, cmp_hit & {NUM_MOD{lane_en}}, phase_error_out_o & {NUM_MOD{lane_en}}};
      irq_clr = '0;
      if (wr_go && avs_address_i == OFS_IRQ_CLR && avs_byteenable_i[0]) begin
         irq_clr = avs_writedata_i[IRQ_W-1:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (rst_i) begin
         irq_stat_reg <= '0;
         irq_o        <= 1'b0;
      end else if (ce_i) begin
         irq_stat_reg <= (irq_stat_reg & ~irq_clr) | irq_set;
         irq_o        <= |(((irq_stat_reg & ~irq_clr) | irq_set) & irq_en_reg);
      end
   end

   property p_set_wins;
      @(posedge mclk_i) disable iff (rst_i)
      (ce_i && irq_set[IRQ_ERR_LSB] && irq_clr[IRQ_ERR_LSB]) |=> irq_stat_reg[IRQ_ERR_LSB];
   endproperty
   a_set_wins: assert property (p_set_wins) else $error("error event lost to clear"); // R3

   property p_set_wins_cmp;
      @(posedge mclk_i) disable iff (rst_i)
      (ce_i && irq_set[IRQ_CMP_LSB] && irq_clr[IRQ_CMP_LSB]) |=> irq_stat_reg[IRQ_CMP_LSB];
   endproperty
   a_set_wins_cmp: assert property (p_set_wins_cmp) else $error("compare event lost to clear"); // R14

   property p_reset_run;
      @(posedge mclk_i) disable iff (rst_i)
      $fell(rst_i) |-> !clk_dis_reg[CLK_DIS_BIT] && enc_en;
   endproperty
   a_reset_run: assert property (p_reset_run) else $error("encoder clock off after reset"); // R2

   property p_bus_ack;
      @(posedge mclk_i) disable iff (rst_i)
      (ce_i && (avs_read_i || avs_write_i) && avs_waitrequest_o) |=>
         !avs_waitrequest_o ##1 (!$past(ce_i) || avs_waitrequest_o);
   endproperty
   a_bus_ack: assert property (p_bus_ack) else $error("bus answer timing wrong");
endmodule : quadrature_encoder_integration

/* File: tb/encoder_model.sv */
`timescale 1ns/1ps
module encoder_model (
   input  wire logic       mclk_i, // peripheral clock
   output logic      [1:0] a_o,    // phase A per module
   output logic      [1:0] b_o,    // phase B per module
   output logic      [1:0] i_o,    // index per module
   output logic      [1:0] s_o     // strobe per module
);
   initial begin
      a_o = '0;
      b_o = '0;
      i_o = '0;
      s_o = '0;
   end
   // one forward gray step, then hold long enough for sync plus filter
   task automatic step(input int m, input int hold);
      if (a_o[m] == b_o[m]) a_o[m] <= ~a_o[m];
      else b_o[m] <= ~b_o[m];
      repeat (hold) @(posedge mclk_i);
   endtask : step
   // both phases at once: only ever used to provoke an error
   task automatic bad(input int m, input int hold);
      a_o[m] <= ~a_o[m];
      b_o[m] <= ~b_o[m];
      repeat (hold) @(posedge mclk_i);
   endtask : bad
   task automatic pulse(input bit strb, input int m, input int hold);
      if (strb) s_o[m] <= 1'b1;
      else i_o[m] <= 1'b1;
      repeat (hold) @(posedge mclk_i);
      if (strb) s_o[m] <= 1'b0;
      else i_o[m] <= 1'b0;
      repeat (hold) @(posedge mclk_i);
   endtask : pulse
endmodule : encoder_model

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   import qei_pkg::*;
   logic        mclk_i = 1'b0;
   logic        rst_i = 1'b1;
   logic [7:0]  avs_address_i = '0;
   logic        avs_read_i = 1'b0;
   logic        avs_write_i = 1'b0;
   logic [31:0] avs_writedata_i = '0;
   logic [31:0] avs_readdata_o;
   logic        avs_waitrequest_o;
   logic [1:0]  phase_a_in_i, phase_b_in_i, index_in_i, strobe_in_i;
   logic [1:0]  phase_error_out_o, compare_sync_o;
   logic        timer_phase_error_n_o, irq_o;
   logic [31:0] rd;
   int          error_cnt = 0;
   int          n_tests = 0;

   always #5 mclk_i = ~mclk_i;

   quadrature_encoder_integration dut_u (.mclk_i, .rst_i, .ce_i(1'b1), .avs_address_i, .avs_read_i,
      .avs_write_i, .avs_writedata_i, .avs_byteenable_i(4'hf), .avs_readdata_o, .avs_waitrequest_o,
      .phase_a_in_i, .phase_b_in_i, .index_in_i, .strobe_in_i, .phase_error_out_o,
      .timer_phase_error_n_o, .compare_sync_o, .irq_o);
   encoder_model enc_u (.mclk_i, .a_o(phase_a_in_i), .b_o(phase_b_in_i), .i_o(index_in_i),
      .s_o(strobe_in_i));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_tests++;
      if (got !== exp) begin
         error_cnt++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : chk
   // read right after the edge: design updates land later, so this is what the edge sampled
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      avs_address_i   <= a;
      avs_writedata_i <= wd;
      avs_write_i     <= wr;
      avs_read_i      <= ~wr;
      @(posedge mclk_i);
      while (avs_waitrequest_o !== 1'b0) begin
         @(posedge mclk_i);
      end
      rd = avs_readdata_o;
      avs_read_i  <= 1'b0;
      avs_write_i <= 1'b0;
      // one idle edge so a following call never reassigns in this time step
      @(posedge mclk_i);
   endtask : bus
   task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rd_chk
   // compare sync must stay low through lo edges and be high by hi edges
   task automatic sync_win(input int hold, input int lo, input int hi);
      repeat (lo - hold) @(posedge mclk_i);
      @(negedge mclk_i);
      chk(compare_sync_o[0], 1'b0);
      repeat (hi - lo) @(posedge mclk_i);
      @(negedge mclk_i);
      chk(compare_sync_o[0], 1'b1);
      @(posedge mclk_i);
   endtask : sync_win

   task automatic sc_reset;
      rd_chk(OFS_CLK_DIS, 32'h0000_0000);
      rd_chk(OFS_PATH_SEL, 32'h0101_0101);
      rd_chk(8'hfc, 32'h0000_0000);
      chk(timer_phase_error_n_o, 1'b1);
      chk(phase_error_out_o, 2'b00);
      chk(compare_sync_o, 2'b00);
      chk(irq_o, 1'b0);
   endtask : sc_reset
   task automatic sc_plain;
      for (int k = 1; k <= 2; k++) begin
         bus(1'b1, OFS_CMP0, k);
         enc_u.step(0, 2);
         sync_win(2, 4, 6);
      end
      rd_chk(OFS_POS0, 32'h0000_0002);
   endtask : sc_plain
   task automatic sc_filt;
      bus(1'b1, OFS_FILT_W, 32'h0000_0003);
      bus(1'b1, OFS_PATH_SEL, 32'h0202_0202);
      for (int k = 3; k <= 4; k++) begin
         bus(1'b1, OFS_CMP0, k);
         enc_u.step(0, 5);
         sync_win(5, 8, 10);
      end
      // both select bits clear falls back to the plain path
      bus(1'b1, OFS_PATH_SEL, 32'h0000_0000);
      bus(1'b1, OFS_CMP0, 32'h0000_0005);
      enc_u.step(0, 2);
      sync_win(2, 4, 6);
      bus(1'b1, OFS_PATH_SEL, 32'h0101_0101);
   endtask : sc_filt
   task automatic sc_idx_strobe;
      // count still equals compare: the hit keeps setting while cleared
      bus(1'b1, OFS_IRQ_CLR, 32'h0000_0004);
      rd_chk(OFS_IRQ_STAT, 32'h0000_0004);
      enc_u.pulse(1'b1, 0, 2);
      repeat (6) @(posedge mclk_i);
      rd_chk(OFS_LATCH0, 32'h0000_0005);
      enc_u.pulse(1'b0, 0, 2);
      repeat (6) @(posedge mclk_i);
      rd_chk(OFS_POS0, 32'h0000_0000);
   endtask : sc_idx_strobe
   task automatic sc_err;
      int e, t;
      chk(irq_o, 1'b0);
      bus(1'b1, OFS_IRQ_EN, 32'h0000_0002);
      for (int s = 1; s >= 0; s--) begin
         bus(1'b1, OFS_ERR_SEL, s);
         enc_u.bad(1, 2);
         e = 0;
         t = 0;
         repeat (8) begin
            @(negedge mclk_i);
            if (phase_error_out_o[1] === 1'b1) e++;
            if (timer_phase_error_n_o === 1'b0) t++;
         end
         @(posedge mclk_i);
         chk(e, 1);
         chk(t, s);
         chk(irq_o, 1'b1);
         bus(1'b0, OFS_IRQ_STAT, 32'h0);
         chk(rd & 32'h2, 32'h2);
         bus(1'b1, OFS_IRQ_CLR, 32'h0000_0002);
         repeat (2) @(posedge mclk_i);
         chk(irq_o, 1'b0);
      end
   endtask : sc_err
   task automatic sc_clkdis;
      bus(1'b1, OFS_CLK_DIS, 32'h0000_0200);
      rd_chk(OFS_CLK_DIS, 32'h0000_0200);
      enc_u.step(0, 2);
      repeat (8) @(posedge mclk_i);
      rd_chk(OFS_POS0, 32'h0000_0000);
   endtask : sc_clkdis

   task automatic end_of_test;
      $display("comparisons %0d mismatches %0d", n_tests, error_cnt);
      if (error_cnt == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask : end_of_test

   initial begin
      repeat (3) @(posedge mclk_i);
      rst_i <= 1'b0;
      @(posedge mclk_i);
      sc_reset();
      sc_plain();
      sc_filt();
      sc_idx_strobe();
      sc_err();
      sc_clkdis();
      end_of_test();
   end
   // whole run is well under 2000 cycles
   initial begin
      repeat (20000) @(posedge mclk_i);
      error_cnt++;
      end_of_test();
   end
endmodule : tb
